// ### rtl/camac_packer_pkg.sv
// constants, register map and state codes for the event buffer packer
// shared by the packer and by the verification side; no logic here
package camac_packer_pkg;

  // word and memory geometry
  localparam int DATA_W = 16;
  localparam int EV_DEPTH_DEF = 2048;
  localparam int BUF_WORDS_DEF = 4096;
  localparam int EV_CNT_W = 12;
  localparam int BUF_CNT_W = 13;
  localparam int USB_FIFO_BYTES = 512;
  localparam int USB_MAX_BYTES = 8192;
  localparam logic [3:0] MAX_LEN_CODE = 4'h8;

  // register offsets on the plain register port
  localparam logic [3:0] REG_ACTION = 4'h0;
  localparam logic [3:0] REG_GLOBAL_MODE = 4'h1;
  localparam logic [3:0] REG_BUF_OPTIONS = 4'h2;
  localparam logic [3:0] REG_TRIG_DELAY = 4'h3;
  localparam logic [3:0] REG_LAM_TIMEOUT = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;

  // field positions
  localparam int ACT_RUN_BIT = 0;
  localparam int OPT_HDR2_BIT = 0;
  localparam int OPT_TERM2_BIT = 1;
  localparam int OPT_NOTERM_BIT = 2;
  localparam int OPT_SPLIT_BIT = 3;
  localparam int HDR_WDOG_BIT = 15;
  localparam int HDR_SCALER_BIT = 14;
  localparam int HDR_AUTO_BIT = 13;
  localparam int LEN_PART_BIT = 12;
  localparam int REPLY_X_BIT = 1;
  localparam int REPLY_Q_BIT = 0;
  localparam int LONG_Q_BIT = 8;
  localparam int LONG_X_BIT = 9;

  // values after reset
  localparam logic [3:0] GLOBAL_MODE_RST = 4'h0;
  localparam logic [15:0] BUF_OPTIONS_RST = 16'h0000;
  localparam logic [15:0] TRIG_DELAY_RST = 16'h0000;
  localparam logic [15:0] LAM_TIMEOUT_RST = 16'h0000;

  // fixed words
  localparam logic [15:0] EV_TERM_WORD = 16'hFFFF;
  localparam logic [15:0] BUF_TERM_WORD = 16'hFFFF;

  // function code bounds
  localparam logic [4:0] F_WRITE_LO = 5'h10;
  localparam logic [4:0] F_WRITE_HI = 5'h17;
  localparam logic [4:0] F_CTRL_A_LO = 5'h07;
  localparam logic [4:0] F_CTRL_A_HI = 5'h0F;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_FMT   = 7'b000_0010,
    ST_CHK   = 7'b000_0100,
    ST_COPY  = 7'b000_1000,
    ST_HDR   = 7'b001_0000,
    ST_BODY  = 7'b010_0000,
    ST_BTERM = 7'b100_0000
  } pack_state_t;

endpackage

// ### rtl/camac_event_buffer_packer.sv
// camac_event_buffer_packer: formats command replies and list-mode events
// into 16-bit words for the usb bulk-in fifo.
// assumes: sequencer on the same clock, usb_full is an almost-full flag
// from the usb controller fifo on the same clock, nim input is asynchronous.
// How it works
// - all output leaves through bulk-in word port
// - register and stack readback passes raw
// - last write of stack returns XQ word
// - options bit 3 selects split packing
// - header holds watchdog, scaler, event count
// - optional second header holds word count
// - length word counts data plus terminators
// - terminators optional, second optional, omittable
// - default is one FFFF terminator per event
// - integer buffers end in FFFF, split none
// - direct command reply has no header
// - write reply: X bit1, Q bit0
// - short read: one word of data
// - long read: two words, Q/X in second
// - 2k event fifo, parts marked bit 12
// - only final part carries terminators
// - oversize event forces split, header bit13
// - control functions reply like a write; F15 here replies with data
// - trigger runs stack, events fill buffers
// - nim trigger delayed, LAM wait bounded
// - mode bits 0-3 pick buffer length
// - action bit 0 starts and stops acquisition
// - long flag selects two-word reply
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module camac_event_buffer_packer
  import camac_packer_pkg::*;
#(
  parameter int EV_DEPTH = camac_packer_pkg::EV_DEPTH_DEF,
  parameter int BUF_WORDS = camac_packer_pkg::BUF_WORDS_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic user_nim_input_one,
  output logic stack_start,
  input wire logic lam_wait,
  output logic lam_timeout,
  output logic seq_ready,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_f,
  input wire logic cmd_long,
  input wire logic cmd_last,
  input wire logic [23:0] cmd_data,
  input wire logic cmd_q,
  input wire logic cmd_x,
  input wire logic raw_valid,
  input wire logic [15:0] raw_word,
  input wire logic raw_last,
  input wire logic evt_end,
  input wire logic evt_scaler,
  output logic acquiring,
  input wire logic usb_full,
  output logic [15:0] usb_data,
  output logic usb_wr,
  output logic usb_commit
);
  import camac_packer_pkg::*;

  // buffers up to the largest host transfer; fields are sized for the defaults
  if (BUF_WORDS * 2 > USB_MAX_BYTES || BUF_WORDS > 4096 || EV_DEPTH > 2048 ||
      EV_DEPTH < 2 || EV_DEPTH >= BUF_WORDS) begin : g_bad_geometry
    $error("packer geometry not supported");
  end

  typedef struct packed {
    pack_state_t st;
    logic run;
    logic [3:0] gmode;
    logic [15:0] bopt;
    logic [15:0] tdly;
    logic [15:0] lto;
    logic [15:0] rdata;
    logic s1;
    logic s2;
    logic s3;
    logic drun;
    logic [15:0] dcnt;
    logic start;
    logic [15:0] lcnt;
    logic ltmo;
    logic [15:0] p0;
    logic [15:0] p1;
    logic [1:0] pn;
    logic direct;
    logic dlast;
    logic [EV_CNT_W-1:0] ev_cnt;
    logic ev_last;
    logic [BUF_CNT_W-1:0] cpos;
    logic [BUF_CNT_W-1:0] bwp;
    logic [9:0] nev;
    logic scal;
    logic auto_split;
    logic wdog;
    logic [BUF_CNT_W-1:0] oidx;
    logic resume;
    logic [15:0] udata;
    logic uwr;
    logic ucommit;
  } pack_regs_t;

  pack_regs_t r;
  pack_regs_t next_r;

  logic [15:0] ev_mem [EV_DEPTH];
  logic [15:0] buf_mem [BUF_WORDS];
  logic ev_we;
  logic [10:0] ev_wa;
  logic buf_we;
  logic [11:0] buf_wa;
  logic [15:0] buf_wd;

  logic integer_mode;
  logic [1:0] terms;
  logic [1:0] hdrs;
  logic [BUF_CNT_W-1:0] buflen;
  logic [BUF_CNT_W-1:0] cap;
  logic [BUF_CNT_W-1:0] total;
  logic [3:0] len_code;
  logic flush_need;
  logic is_write;
  logic xq_fn;

  always_comb begin
    integer_mode = !r.bopt[OPT_SPLIT_BIT] && !r.auto_split;
    if (!r.ev_last || r.bopt[OPT_NOTERM_BIT]) begin
      terms = 2'd0;
    end else if (r.bopt[OPT_TERM2_BIT]) begin
      terms = 2'd2;
    end else begin
      terms = 2'd1;
    end
    hdrs = r.bopt[OPT_HDR2_BIT] ? 2'd2 : 2'd1;
    len_code = (r.gmode > MAX_LEN_CODE) ? MAX_LEN_CODE : r.gmode;
    buflen = BUF_CNT_W'(BUF_WORDS) >> len_code;
    cap = buflen - BUF_CNT_W'(hdrs) - BUF_CNT_W'(integer_mode);
    total = BUF_CNT_W'(r.ev_cnt) + BUF_CNT_W'(terms) + 13'h0001;
    flush_need = !r.run && (r.ev_cnt != '0 || r.bwp != '0);
    is_write = cmd_f >= F_WRITE_LO && cmd_f <= F_WRITE_HI;
    xq_fn = is_write || (cmd_f > F_CTRL_A_LO && cmd_f < F_CTRL_A_HI) ||
            cmd_f > F_WRITE_HI;
  end

  assign seq_ready = (r.st == ST_IDLE) && !flush_need;

  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.ltmo = 1'b0;
    next_r.uwr = 1'b0;
    next_r.ucommit = 1'b0;
    ev_we = 1'b0;
    ev_wa = 11'(r.ev_cnt);
    buf_we = 1'b0;
    buf_wa = 12'(r.bwp);
    buf_wd = '0;

    // register port
    if (reg_wr) begin
      case (reg_addr)
        REG_ACTION: begin
          next_r.run = reg_wdata[ACT_RUN_BIT];
          if (reg_wdata[ACT_RUN_BIT] && !r.run) begin
            next_r.auto_split = 1'b0;
          end
        end
        REG_GLOBAL_MODE: next_r.gmode = reg_wdata[3:0];
        REG_BUF_OPTIONS: next_r.bopt = reg_wdata;
        REG_TRIG_DELAY: next_r.tdly = reg_wdata;
        REG_LAM_TIMEOUT: next_r.lto = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_ACTION: next_r.rdata = {15'h0000, r.run};
        REG_GLOBAL_MODE: next_r.rdata = {12'h000, r.gmode};
        REG_BUF_OPTIONS: next_r.rdata = r.bopt;
        REG_TRIG_DELAY: next_r.rdata = r.tdly;
        REG_LAM_TIMEOUT: next_r.rdata = r.lto;
        REG_STATUS: next_r.rdata = {r.auto_split, r.run, 4'h0, r.nev};
        default: next_r.rdata = 16'h0000;
      endcase
    end

    // trigger: synchronise, detect rising edge, wait the programmed delay
    next_r.s1 = user_nim_input_one;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.drun) begin
      if (r.dcnt == 16'h0000) begin
        next_r.drun = 1'b0;
        next_r.start = 1'b1;
      end else begin
        next_r.dcnt = r.dcnt - 16'h0001;
      end
    end else if (r.run && r.s2 && !r.s3) begin
      next_r.drun = 1'b1;
      next_r.dcnt = r.tdly;
    end

    // lam wait bound; a zero timeout disables it
    if (!lam_wait) begin
      next_r.lcnt = 16'h0000;
    end else if (r.lcnt != r.lto) begin
      next_r.lcnt = r.lcnt + 16'h0001;
      next_r.ltmo = (r.lcnt + 16'h0001) == r.lto;
    end

    case (r.st)
      ST_IDLE: begin
        if (!r.run && r.ev_cnt != '0) begin
          next_r.ev_last = 1'b1;
          next_r.st = ST_CHK;
        end else if (!r.run && r.bwp != '0) begin
          next_r.wdog = 1'b1;
          next_r.resume = 1'b0;
          next_r.st = ST_HDR;
        end else if (cmd_valid) begin
          next_r.direct = !r.run;
          next_r.dlast = cmd_last;
          next_r.p0 = cmd_data[15:0];
          next_r.p1 = {6'h00, cmd_x, cmd_q, cmd_data[23:16]};
          if (xq_fn) begin
            next_r.p0 = 16'h0000;
            next_r.p0[REPLY_X_BIT] = cmd_x;
            next_r.p0[REPLY_Q_BIT] = cmd_q;
            next_r.pn = cmd_last ? 2'd1 : 2'd0;
          end else begin
            next_r.pn = cmd_long ? 2'd2 : 2'd1;
          end
          if (!xq_fn || cmd_last) begin
            next_r.st = ST_FMT;
          end
        end else if (raw_valid) begin
          next_r.direct = 1'b1;
          next_r.dlast = raw_last;
          next_r.p0 = raw_word;
          next_r.pn = 2'd1;
          next_r.st = ST_FMT;
        end else if (evt_end && r.run) begin
          next_r.ev_last = 1'b1;
          next_r.scal = r.scal | evt_scaler;
          next_r.st = ST_CHK;
        end
      end
      ST_FMT: begin
        if (r.direct) begin
          if (!usb_full) begin
            next_r.udata = r.p0;
            next_r.uwr = 1'b1;
            next_r.p0 = r.p1;
            next_r.pn = r.pn - 2'd1;
            if (r.pn == 2'd1) begin
              next_r.ucommit = r.dlast;
              next_r.st = ST_IDLE;
            end
          end
        end else if (r.ev_cnt == EV_CNT_W'(EV_DEPTH)) begin
          next_r.ev_last = 1'b0;
          next_r.st = ST_CHK;
        end else begin
          ev_we = 1'b1;
          next_r.ev_cnt = r.ev_cnt + 12'h001;
          next_r.p0 = r.p1;
          next_r.pn = r.pn - 2'd1;
          if (r.pn == 2'd1) begin
            next_r.st = ST_IDLE;
          end
        end
      end
      ST_CHK: begin
        next_r.cpos = '0;
        if (integer_mode && total > cap) begin
          next_r.auto_split = 1'b1;
        end else if (integer_mode && r.bwp + total > cap) begin
          next_r.resume = 1'b1;
          next_r.st = ST_HDR;
        end else begin
          next_r.st = ST_COPY;
        end
      end
      ST_COPY: begin
        if (r.bwp == cap) begin
          // only reached in split packing: the event carries on in the next buffer
          next_r.resume = 1'b1;
          next_r.st = ST_HDR;
        end else begin
          buf_we = 1'b1;
          if (r.cpos == '0) begin
            buf_wd = {3'b000, !r.ev_last, 12'(total - 13'h0001)};
            next_r.nev = r.nev + 10'h001;
          end else if (r.cpos <= BUF_CNT_W'(r.ev_cnt)) begin
            buf_wd = ev_mem[11'(r.cpos - 13'h0001)];
          end else begin
            buf_wd = EV_TERM_WORD;
          end
          next_r.bwp = r.bwp + 13'h0001;
          next_r.cpos = r.cpos + 13'h0001;
          if (r.cpos == total - 13'h0001) begin
            next_r.ev_cnt = '0;
            next_r.ev_last = 1'b0;
            next_r.resume = 1'b0;
            next_r.st = (r.pn != 2'd0) ? ST_FMT : ST_IDLE;
          end
        end
      end
      ST_HDR: begin
        if (!usb_full) begin
          next_r.uwr = 1'b1;
          if (r.oidx == '0) begin
            next_r.udata = {r.wdog, r.scal, r.auto_split, 3'b000, r.nev};
            next_r.oidx = 13'h0001;
            if (!r.bopt[OPT_HDR2_BIT]) begin
              next_r.oidx = '0;
              next_r.st = ST_BODY;
            end
          end else begin
            next_r.udata = {4'h0, 12'(r.bwp)};
            next_r.oidx = '0;
            next_r.st = ST_BODY;
          end
        end
      end
      ST_BODY: begin
        if (r.bwp == '0) begin
          next_r.st = ST_BTERM;
        end else if (!usb_full) begin
          next_r.udata = buf_mem[12'(r.oidx)];
          next_r.uwr = 1'b1;
          next_r.oidx = r.oidx + 13'h0001;
          if (r.oidx == r.bwp - 13'h0001) begin
            next_r.st = ST_BTERM;
          end
        end
      end
      ST_BTERM: begin
        // split buffers close without a terminator word
        if (!integer_mode || !usb_full) begin
          if (integer_mode) begin
            next_r.udata = BUF_TERM_WORD;
            next_r.uwr = 1'b1;
          end
          next_r.ucommit = 1'b1;
          next_r.bwp = '0;
          next_r.nev = '0;
          next_r.scal = 1'b0;
          next_r.wdog = 1'b0;
          next_r.oidx = '0;
          if (!r.resume) begin
            next_r.st = ST_IDLE;
          end else begin
            next_r.st = (r.cpos == '0) ? ST_CHK : ST_COPY;
          end
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.gmode <= GLOBAL_MODE_RST;
      r.bopt <= BUF_OPTIONS_RST;
      r.tdly <= TRIG_DELAY_RST;
      r.lto <= LAM_TIMEOUT_RST;
    end else begin
      r <= next_r;
    end
  end

  // memories carry no reset; contents are only read below the write pointers
  always_ff @(posedge clk) begin
    if (ev_we) begin
      ev_mem[ev_wa] <= r.p0;
    end
    if (buf_we) begin
      buf_mem[buf_wa] <= buf_wd;
    end
  end

  assign reg_rdata = r.rdata;
  assign stack_start = r.start;
  assign lam_timeout = r.ltmo;
  assign acquiring = r.run;
  assign usb_data = r.udata;
  assign usb_wr = r.uwr;
  assign usb_commit = r.ucommit;

endmodule // camac_event_buffer_packer

`default_nettype wire

// ### tb/camac_packer_chk.sv
// checker: reply timing and handshakes of the packer, seen at its ports
// assumes one clock domain; bound onto the packer by the bench
`timescale 1ns/1ps
`default_nettype none
module camac_packer_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic seq_ready,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_f,
  input wire logic cmd_long,
  input wire logic cmd_last,
  input wire logic [23:0] cmd_data,
  input wire logic cmd_q,
  input wire logic cmd_x,
  input wire logic acquiring,
  input wire logic usb_full,
  input wire logic [15:0] usb_data,
  input wire logic usb_wr,
  input wire logic stack_start,
  input wire logic lam_timeout
);
  logic [15:0] data_lo;
  logic [7:0] data_hi;
  logic take;
  assign data_lo = cmd_data[15:0];
  assign data_hi = cmd_data[23:16];
  assign take = cmd_valid && seq_ready && !acquiring && !usb_full;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_take_s;
    take && cmd_last && cmd_f[4:3] == 2'b10 ##1 !usb_full;
  endsequence
  sequence rd_take_s;
    take && cmd_last && cmd_f[4:3] == 2'b00 ##1 !usb_full;
  endsequence
  a_write_xq_word: assert property (wr_take_s |=> usb_wr && usb_data[1:0] ==
    {$past(cmd_x, 2), $past(cmd_q, 2)}) else $error("write reply word wrong");
  a_short_read_word: assert property (rd_take_s and !cmd_long |=>
    usb_wr && usb_data == $past(data_lo, 2)) else $error("short read word wrong");
  a_long_read_high: assert property ((rd_take_s and cmd_long) ##1 !usb_full |=>
    usb_wr && usb_data[9:0] == {$past(cmd_x, 3), $past(cmd_q, 3), $past(data_hi, 3)})
    else $error("long read second word wrong");
  a_busy_after_take: assert property (take && cmd_last && !cmd_f[4] |=> !seq_ready)
    else $error("packer ready while replying");
  a_nonlast_quiet: assert property (take && !cmd_last && cmd_f[4] |=>
    (seq_ready && !usb_wr) [*3]) else $error("non-last write answered");
  a_full_no_write: assert property (usb_full |=> !usb_wr)
    else $error("word written while fifo full");
  a_start_one_pulse: assert property (stack_start |=> !stack_start)
    else $error("stack start longer than one cycle");
  a_lam_one_pulse: assert property (lam_timeout |=> !lam_timeout)
    else $error("lam timeout longer than one cycle");
endmodule // camac_packer_chk
`default_nettype wire

// ### tb/camac_usb_fifo_model.sv
// usb bulk-in fifo with its host reader: keeps every word in arrival order
// assumes the host drains at once, so full follows only the stall request
`timescale 1ns/1ps
`default_nettype none
module camac_usb_fifo_model (
  input wire logic clk,
  input wire logic [15:0] usb_data,
  input wire logic usb_wr,
  input wire logic usb_commit,
  input wire logic stall,
  output logic usb_full
);
  logic [16:0] words[$];
  // split buffers close with a commit and no word; count those separately
  int lone_commits = 0;
  assign usb_full = stall; // host keeps emptying the fifo
  always @(posedge clk) begin
    if (usb_wr) begin
      words.push_back({usb_commit, usb_data}); // whole buffers read
    end
    if (usb_commit && !usb_wr) begin
      lone_commits++;
    end
  end
endmodule // camac_usb_fifo_model
`default_nettype wire

// ### tb/camac_event_buffer_packer_bench.sv
// bench for the packer: register port, command and readback replies, list mode
// assumes the package constants; the usb side is the fifo model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("FAIL %0t got %h want %h", $time, a, b); end end
module camac_event_buffer_packer_bench;
  import camac_packer_pkg::*;
  logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, user_nim_input_one = 0, lam_wait = 0;
  logic cmd_valid = 0, cmd_long = 0, cmd_last = 0, cmd_q = 0, cmd_x = 0, raw_valid = 0;
  logic raw_last = 0, evt_end = 0, evt_scaler = 0, stall = 0;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, raw_word = 0;
  logic [4:0] cmd_f = 0;
  logic [23:0] cmd_data = 0;
  logic [15:0] reg_rdata, usb_data;
  logic stack_start, lam_timeout, seq_ready, acquiring, usb_full, usb_wr, usb_commit;
  logic [23:0] d;
  int checks = 0, fail_count = 0;
  camac_event_buffer_packer dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .user_nim_input_one, .stack_start, .lam_wait, .lam_timeout, .seq_ready,
    .cmd_valid, .cmd_f, .cmd_long, .cmd_last, .cmd_data, .cmd_q, .cmd_x, .raw_valid,
    .raw_word, .raw_last, .evt_end, .evt_scaler, .acquiring, .usb_full, .usb_data, .usb_wr,
    .usb_commit);
  camac_usb_fifo_model mdl (.clk, .usb_data, .usb_wr, .usb_commit, .stall, .usb_full);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, v)
    @(posedge clk);
  endtask
  // one request on the command, readback or event-end port, once ready
  task automatic send(input int k, input logic [4:0] f, input logic lng, input logic last,
      input logic [23:0] v);
    int n;
    n = 0;
    #1;
    while (seq_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmd_f <= f;
    cmd_long <= lng;
    cmd_last <= last;
    raw_last <= last;
    cmd_data <= v;
    raw_word <= v[15:0];
    cmd_q <= v[0];
    cmd_x <= v[1];
    cmd_valid <= k == 0;
    raw_valid <= k == 1;
    evt_end <= k == 2;
    @(posedge clk);
    cmd_valid <= 1'b0;
    raw_valid <= 1'b0;
    evt_end <= 1'b0;
  endtask
  task automatic expw(input logic [15:0] v, input logic c);
    int n;
    logic [16:0] w;
    n = 0;
    while (mdl.words.size() == 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    w = mdl.words.size() > 0 ? mdl.words.pop_front() : 17'bx;
    `CHK(w, {c, v})
  endtask
  task automatic evw(input int e);
    expw(16'h0003, 1'b0);
    expw(16'(256 + 2 * e), 1'b0);
    expw(16'(257 + 2 * e), 1'b0);
    expw(EV_TERM_WORD, 1'b0);
  endtask
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #50000;
    fail_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rreg(REG_GLOBAL_MODE, 16'h0000);
    rreg(REG_BUF_OPTIONS, 16'h0000);
    rreg(4'hF, 16'h0000);
    // every function code: writes and controls except F15 answer x/q, the rest data
    for (int f = 0; f < 32; f++) begin
      d = 24'h5a_c3a6 ^ 24'(f * 5);
      send(0, f[4:0], 1'b0, 1'b1, d);
      if (f > 15 || (f > 7 && f < 15)) begin
        expw({14'h0000, d[1:0]}, 1'b1);
      end else begin
        expw(d[15:0], 1'b1);
      end
    end
    stall <= 1'b1;
    send(0, 5'h02, 1'b1, 1'b1, 24'hab_1237);
    repeat (6) @(posedge clk);
    stall <= 1'b0;
    expw(16'h1237, 1'b0);
    expw(16'h03ab, 1'b1);
    // long read with the fifo open, so the two-word reply runs back to back
    send(0, 5'h01, 1'b1, 1'b1, 24'h5c_4a95);
    expw(16'h4a95, 1'b0);
    expw(16'h015c, 1'b1);
    send(0, 5'h10, 1'b0, 1'b0, 24'h00_0003);
    repeat (6) @(posedge clk);
    `CHK(mdl.words.size(), 0)
    send(1, 5'h00, 1'b0, 1'b0, 24'h00_beef);
    send(1, 5'h00, 1'b0, 1'b1, 24'h00_0001);
    expw(16'hbeef, 1'b0);
    expw(16'h0001, 1'b1);
    wreg(REG_LAM_TIMEOUT, 16'h0004);
    lam_wait <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK(lam_timeout, 1'b0)
    @(posedge clk);
    #1 `CHK(lam_timeout, 1'b1)
    @(posedge clk);
    #1 `CHK(lam_timeout, 1'b0)
    repeat (14) @(posedge clk);
    lam_wait <= 1'b0;
    // 16-word buffers: three 4-word events fit, the fourth forces emission
    wreg(REG_GLOBAL_MODE, 16'h0008);
    wreg(REG_ACTION, 16'h0001);
    repeat (2) @(posedge clk);
    `CHK(acquiring, 1'b1)
    user_nim_input_one <= 1'b1;
    for (int n = 0; n < 20 && stack_start !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK(stack_start, 1'b1)
    user_nim_input_one <= 1'b0;
    for (int e = 0; e < 4; e++) begin
      send(0, 5'h00, 1'b0, 1'b0, 24'(256 + 2 * e));
      send(0, 5'h00, 1'b0, 1'b1, 24'(257 + 2 * e));
      send(2, 5'h00, 1'b0, 1'b0, 24'h00_0000);
    end
    repeat (30) @(posedge clk);
    wreg(REG_ACTION, 16'h0000);
    expw(16'h0003, 1'b0);
    for (int e = 0; e < 3; e++) begin
      evw(e);
    end
    expw(BUF_TERM_WORD, 1'b1);
    expw(16'h8001, 1'b0);
    evw(3);
    expw(BUF_TERM_WORD, 1'b1);
    // oversize event in integer packing: packing turns to split on its own
    wreg(REG_ACTION, 16'h0001);
    for (int i = 0; i < 14; i++) begin
      send(0, 5'h00, 1'b0, 1'b0, 24'(i));
    end
    send(2, 5'h00, 1'b0, 1'b0, 24'h00_0000);
    expw(16'h2001, 1'b0);
    expw(16'h000f, 1'b0);
    for (int i = 0; i < 14; i++) begin
      expw(16'(i), 1'b0);
    end
    wreg(REG_ACTION, 16'h0000);
    expw(16'ha000, 1'b0);
    expw(EV_TERM_WORD, 1'b0);
    repeat (5) @(posedge clk);
    `CHK(mdl.lone_commits, 2)
    // split packing chosen by option, second header, two terminators, scaler event
    wreg(REG_BUF_OPTIONS, 16'h000b);
    wreg(REG_ACTION, 16'h0001);
    send(0, 5'h00, 1'b0, 1'b0, 24'h00_1234);
    send(0, 5'h00, 1'b0, 1'b0, 24'h00_5678);
    evt_scaler <= 1'b1;
    send(2, 5'h00, 1'b0, 1'b0, 24'h00_0000);
    evt_scaler <= 1'b0;
    repeat (10) @(posedge clk);
    wreg(REG_ACTION, 16'h0000);
    expw(16'hc001, 1'b0);
    expw(16'h0005, 1'b0);
    expw(16'h0004, 1'b0);
    expw(16'h1234, 1'b0);
    expw(16'h5678, 1'b0);
    expw(EV_TERM_WORD, 1'b0);
    expw(EV_TERM_WORD, 1'b0);
    repeat (5) @(posedge clk);
    `CHK(mdl.words.size(), 0)
    `CHK(mdl.lone_commits, 3)
    results();
  end
endmodule // camac_event_buffer_packer_bench
bind camac_event_buffer_packer camac_packer_chk chk (.clk, .reset_n, .seq_ready, .cmd_valid,
  .cmd_f, .cmd_long, .cmd_last, .cmd_data, .cmd_q, .cmd_x, .acquiring, .usb_full, .usb_data,
  .usb_wr, .stack_start, .lam_timeout);
`default_nettype wire
